// ==== verilog/lcd_ext_defs.svh ====
// offsets, field positions, reset values and counts of the lcd extension registers
`ifndef LCD_EXT_DEFS_SVH
`define LCD_EXT_DEFS_SVH
`define IDX_START_HIGH 8'h0C
`define IDX_START_LOW 8'h0D
`define IDX_CURSOR_START 8'h0A
`define IDX_WIN_HIGH 8'hC0
`define IDX_WIN_LOW 8'hC1
`define IDX_DISP_CTRL 8'hC2
`define CHAR_BLINK_MSB 7
`define CHAR_BLINK_LSB 6
`define CURSOR_BLINK_MSB 5
`define CURSOR_BLINK_LSB 4
`define SCREEN_INVERT_BIT 0
`define CURSOR_BLINK_EN_BIT 5
`define WIN_HIGH_MASK 8'h1F
`define START_HIGH_MASK 8'h3F
`define DISP_CTRL_MASK 8'hF1
`define DISP_CTRL_RESET 8'h00
`define REG_RESET 8'h00
`define FRAME_CNT_W 6
`endif

// ==== verilog/lcd_ext_pkg.sv ====
// types shared by the lcd extension block
package lcd_ext_pkg;
  typedef enum logic [1:0] {
    BLINK_STEADY,
    BLINK_64,
    BLINK_32,
    BLINK_16
  } blink_rate_t;
endpackage

// ==== verilog/blink_phase.sv ====
// frame counter giving the visible phase for both blink fields
`timescale 1ns/10ps
`default_nettype none
`include "lcd_ext_defs.svh"
module blink_phase #(
  parameter int CNT_W = `FRAME_CNT_W
) (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // frame tick and rates
  input wire logic frame_tick,
  input wire lcd_ext_pkg::blink_rate_t char_rate,
  input wire lcd_ext_pkg::blink_rate_t cursor_rate,
  // phases, high while visible
  output logic char_on,
  output logic cursor_on
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // steady shows always; otherwise inverted count bit 5, 4 or 3 for 1/64, 1/32, 1/16
  function automatic logic phase_of(input lcd_ext_pkg::blink_rate_t r, input logic [CNT_W-1:0] c);
    case (r)
      lcd_ext_pkg::BLINK_64: phase_of = ~c[5];
      lcd_ext_pkg::BLINK_32: phase_of = ~c[4];
      lcd_ext_pkg::BLINK_16: phase_of = ~c[3];
      default: phase_of = 1'b1;
    endcase
  endfunction

  always_comb begin
    count_next = count_reg;
    if (frame_tick) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_reg <= '0;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

  assign char_on = phase_of(char_rate, count_reg);
  assign cursor_on = phase_of(cursor_rate, count_reg);
endmodule
`default_nettype wire

// ==== verilog/lcd_ext_regs.sv ====
// lcd extension registers: window start, display control and blink
// What this block does
// - separate window start address for small panels
// - reached via shared index and data ports
// - 13-bit window; 0D writes copied into C1
// - char blink field: steady,1/64,1/32,1/16
// - cursor blink same encoding, gated by bit5
// - bit 0 inverts whole panel
// - display control resets to all zero
// - 0C holds full-size start upper byte
`timescale 1ns/10ps
`default_nettype none
`include "lcd_ext_defs.svh"
module lcd_ext_regs (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // index/data port, same clock
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // display timing
  input wire logic frame_tick,
  // outputs to the display path
  output logic [12:0] start_addr,
  output logic [12:0] window_addr,
  output logic [13:0] full_start_addr,
  output logic char_visible,
  output logic cursor_visible,
  output logic screen_invert
);
  logic [7:0] index_reg, index_next;
  logic [7:0] start_high_reg, start_high_next;
  logic [7:0] start_low_reg, start_low_next;
  logic [7:0] cursor_start_reg, cursor_start_next;
  logic [7:0] window_start_high_reg, window_start_high_next;
  logic [7:0] window_start_low_reg, window_start_low_next;
  logic [7:0] display_control_reg, display_control_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [12:0] start_addr_reg, start_addr_next;
  logic [12:0] window_addr_reg, window_addr_next;
  logic [13:0] full_reg, full_next;
  logic char_vis_reg, char_vis_next, cur_vis_reg, cur_vis_next, inv_reg, inv_next;
  logic char_on, cursor_on;
  lcd_ext_pkg::blink_rate_t char_blink_rate, cursor_blink_rate;

  assign char_blink_rate = lcd_ext_pkg::blink_rate_t'(display_control_reg[`CHAR_BLINK_MSB:`CHAR_BLINK_LSB]);
  assign cursor_blink_rate = lcd_ext_pkg::blink_rate_t'(display_control_reg[`CURSOR_BLINK_MSB:`CURSOR_BLINK_LSB]);

  blink_phase #(.CNT_W(`FRAME_CNT_W)) u_phase (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .frame_tick(frame_tick),
    .char_rate(char_blink_rate),
    .cursor_rate(cursor_blink_rate),
    .char_on(char_on),
    .cursor_on(cursor_on)
  );

  always_comb begin
    index_next = index_reg;
    start_high_next = start_high_reg;
    start_low_next = start_low_reg;
    cursor_start_next = cursor_start_reg;
    window_start_high_next = window_start_high_reg;
    window_start_low_next = window_start_low_reg;
    display_control_next = display_control_reg;
    rdata_next = rdata_reg;
    if (index_wr) begin
      index_next = wdata;
    end
    if (data_wr) begin
      case (index_reg)
        `IDX_START_HIGH: start_high_next = wdata & `START_HIGH_MASK;
        `IDX_START_LOW: begin
          start_low_next = wdata;
          window_start_low_next = wdata;
        end
        `IDX_CURSOR_START: cursor_start_next = wdata;
        `IDX_WIN_HIGH: window_start_high_next = wdata & `WIN_HIGH_MASK;
        `IDX_WIN_LOW: window_start_low_next = wdata;
        `IDX_DISP_CTRL: display_control_next = wdata & `DISP_CTRL_MASK;
        default: ;
      endcase
    end
    if (data_rd) begin
      case (index_reg)
        `IDX_START_HIGH: rdata_next = start_high_reg;
        `IDX_START_LOW: rdata_next = start_low_reg;
        `IDX_CURSOR_START: rdata_next = cursor_start_reg;
        `IDX_WIN_HIGH: rdata_next = window_start_high_reg;
        `IDX_WIN_LOW: rdata_next = window_start_low_reg;
        `IDX_DISP_CTRL: rdata_next = display_control_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      index_reg <= `REG_RESET;
      start_high_reg <= `REG_RESET;
      start_low_reg <= `REG_RESET;
      cursor_start_reg <= `REG_RESET;
      window_start_high_reg <= `REG_RESET;
      window_start_low_reg <= `REG_RESET;
      display_control_reg <= `DISP_CTRL_RESET;
      rdata_reg <= `REG_RESET;
    end else if (clk_en) begin
      index_reg <= index_next;
      start_high_reg <= start_high_next;
      start_low_reg <= start_low_next;
      cursor_start_reg <= cursor_start_next;
      window_start_high_reg <= window_start_high_next;
      window_start_low_reg <= window_start_low_next;
      display_control_reg <= display_control_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs registered so the display path sees clean levels
  always_comb begin
    window_addr_next = {window_start_high_reg[4:0], window_start_low_reg};
    full_next = {start_high_reg[5:0], start_low_reg};
    // window replaces the full-size start; routing reads is the host's job
    start_addr_next = window_addr_next;
    char_vis_next = char_on;
    // bit 5 of the cursor start raster holds the cursor steady
    cur_vis_next = cursor_start_reg[`CURSOR_BLINK_EN_BIT] ? 1'b1 : cursor_on;
    inv_next = display_control_reg[`SCREEN_INVERT_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      window_addr_reg <= '0;
      full_reg <= '0;
      start_addr_reg <= '0;
      char_vis_reg <= 1'b1;
      cur_vis_reg <= 1'b1;
      inv_reg <= 1'b0;
    end else if (clk_en) begin
      window_addr_reg <= window_addr_next;
      full_reg <= full_next;
      start_addr_reg <= start_addr_next;
      char_vis_reg <= char_vis_next;
      cur_vis_reg <= cur_vis_next;
      inv_reg <= inv_next;
    end
  end

  assign rdata = rdata_reg;
  assign window_addr = window_addr_reg;
  assign full_start_addr = full_reg;
  assign start_addr = start_addr_reg;
  assign char_visible = char_vis_reg;
  assign cursor_visible = cur_vis_reg;
  assign screen_invert = inv_reg;

  a_low_mirror: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && data_wr && index_reg == `IDX_START_LOW |=> window_start_low_reg == $past(wdata))
    else $error("start low write not copied to window low");
  a_high_mask: assert property (@(posedge clk_sys) disable iff (reset)
    window_start_high_reg[7:5] == 3'b000)
    else $error("window high unused bits set");
  a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    display_control_reg[3:1] == 3'b000)
    else $error("display control reserved bits set");
  a_invert_follow: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> screen_invert == $past(display_control_reg[`SCREEN_INVERT_BIT]))
    else $error("invert output wrong");
  a_steady_char: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && display_control_reg[7:6] == 2'b00 |=> char_visible)
    else $error("steady character blanked");
  a_steady_cursor: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && display_control_reg[5:4] == 2'b00 |=> cursor_visible)
    else $error("steady cursor blanked");
  a_window_addr: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> window_addr == {$past(window_start_high_reg[4:0]), $past(window_start_low_reg)})
    else $error("window address mismatch");
  a_reg_read: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && data_rd && index_reg == `IDX_DISP_CTRL |=> rdata == $past(display_control_reg))
    else $error("display control read wrong");
  a_full_start: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> full_start_addr[13:8] == $past(start_high_reg[5:0]))
    else $error("full start high byte wrong");
endmodule
`default_nettype wire

// ==== testbench/lcd_panel_model.sv ====
// panel stand-in: frame pulses and count of blink flips seen
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model #(
  parameter int FRAME_LEN = 4
) (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  // frame timing
  input wire logic flip_clr,
  output logic frame_tick,
  // observed levels
  input wire logic char_visible,
  input wire logic cursor_visible,
  output var int char_flips,
  output var int cursor_flips
);
  int cnt;
  logic char_d;
  logic cur_d;
  // short frames keep blink periods cheap to watch
  always @(posedge clk_sys) begin
    cnt <= (reset || cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
    frame_tick <= !reset && cnt == FRAME_LEN - 1;
    char_d <= char_visible;
    cur_d <= cursor_visible;
    char_flips <= flip_clr ? 0 : char_flips + int'(char_d !== char_visible);
    cursor_flips <= flip_clr ? 0 : cursor_flips + int'(cur_d !== cursor_visible);
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the lcd extension registers
`timescale 1ns/10ps
`default_nettype none
`include "lcd_ext_defs.svh"
module tb;
  logic clk_sys, reset, clk_en, index_wr, data_wr, data_rd, flip_clr, frame_tick;
  logic [7:0] wdata, rdata, v;
  logic [12:0] start_addr, window_addr;
  logic [13:0] full_start_addr;
  logic char_visible, cursor_visible, screen_invert;
  logic [31:0] seed;
  int char_flips, cursor_flips, num_errors, compares;
  logic [7:0] idxs [6] = '{`IDX_WIN_HIGH, `IDX_WIN_LOW, `IDX_DISP_CTRL, 8'h0C, 8'h0D, 8'h0A};
  lcd_ext_regs u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .index_wr(index_wr),
    .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .frame_tick(frame_tick),
    .start_addr(start_addr), .window_addr(window_addr), .full_start_addr(full_start_addr),
    .char_visible(char_visible), .cursor_visible(cursor_visible), .screen_invert(screen_invert));
  lcd_panel_model #(.FRAME_LEN(4)) u_panel (.clk_sys(clk_sys), .reset(reset), .flip_clr(flip_clr),
    .frame_tick(frame_tick), .char_visible(char_visible), .cursor_visible(cursor_visible),
    .char_flips(char_flips), .cursor_flips(cursor_flips));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // flips in 64 frames: the counter bit toggles 64/half-period times
  function automatic int flips(input logic [1:0] rate);
    return rate == 2'b00 ? 0 : 1 << rate;
  endfunction
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk_val(input string what, input logic [13:0] exp, input logic [13:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    index_wr = 1'b1;
    wdata = idx;
    cyc();
    index_wr = 1'b0;
    data_wr = 1'b1;
    wdata = val;
    cyc();
    data_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    index_wr = 1'b1;
    wdata = idx;
    cyc();
    index_wr = 1'b0;
    data_rd = 1'b1;
    cyc();
    data_rd = 1'b0;
    val = rdata;
  endtask
  task automatic blink(input logic [7:0] ctrl, input logic cur_en);
    wr(`IDX_DISP_CTRL, ctrl);
    cyc(8);
    flip_clr = 1'b1;
    cyc();
    flip_clr = 1'b0;
    cyc(256);
    chk_cnt("char flips", flips(ctrl[7:6]), char_flips);
    chk_cnt("cursor flips", cur_en ? flips(ctrl[5:4]) : 0, cursor_flips);
    if (ctrl[7:6] == 2'b00) chk_val("char steady", 14'h0001, 14'(char_visible));
  endtask
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(10000 * 25);
    num_errors++;
    give_verdict();
  end
  initial begin
    {clk_en, reset} = 2'b11;
    {index_wr, data_wr, data_rd, flip_clr, wdata} = '0;
    seed = 32'hfcb9;
    cyc(16);
    reset = 1'b0;
    foreach (idxs[i]) begin
      rd(idxs[i], v);
      chk_val("reset value", 14'h0000, 14'(v));
    end
    chk_val("reset invert", 14'h0000, 14'(screen_invert));
    // random window and control values reach every field
    repeat (8) begin
      seed = xs(seed);
      wr(`IDX_WIN_HIGH, seed[7:0]);
      wr(`IDX_WIN_LOW, seed[15:8]);
      wr(`IDX_DISP_CTRL, seed[23:16]);
      rd(`IDX_WIN_HIGH, v);
      chk_val("window high", 14'(seed[7:0] & `WIN_HIGH_MASK), 14'(v));
      rd(`IDX_WIN_LOW, v);
      chk_val("window low", 14'(seed[15:8]), 14'(v));
      rd(`IDX_DISP_CTRL, v);
      chk_val("display control", 14'(seed[23:16] & `DISP_CTRL_MASK), 14'(v));
      chk_val("window addr", 14'({seed[4:0], seed[15:8]}), 14'(window_addr));
      chk_val("start addr", 14'({seed[4:0], seed[15:8]}), 14'(start_addr));
      chk_val("invert", 14'(seed[16]), 14'(screen_invert));
    end
    seed = xs(seed);
    wr(`IDX_START_LOW, seed[7:0]);
    wr(`IDX_START_HIGH, seed[15:8]);
    cyc(2);
    rd(`IDX_WIN_LOW, v);
    chk_val("mirrored low", 14'(seed[7:0]), 14'(v));
    rd(`IDX_START_HIGH, v);
    chk_val("start high", 14'(seed[15:8] & `START_HIGH_MASK), 14'(v));
    chk_val("full start", {seed[13:8], seed[7:0]}, full_start_addr);
    wr(8'h55, 8'hFF);
    rd(8'h55, v);
    chk_val("unmapped", 14'h0000, 14'(v));
    // a frozen clock enable must drop the write
    wr(`IDX_DISP_CTRL, 8'h01);
    clk_en = 1'b0;
    wr(`IDX_DISP_CTRL, 8'h00);
    clk_en = 1'b1;
    cyc(2);
    chk_val("frozen invert", 14'h0001, 14'(screen_invert));
    wr(`IDX_CURSOR_START, 8'h00);
    for (int r = 0; r < 4; r++) blink({2'(r), 2'(3 - r), 4'h0}, 1'b1);
    wr(`IDX_CURSOR_START, 8'h20);
    blink(8'hF0, 1'b0);
    // reset must act even while the clock enable is low
    wr(`IDX_DISP_CTRL, 8'hF1);
    {clk_en, reset} = 2'b01;
    cyc(2);
    {clk_en, reset} = 2'b10;
    rd(`IDX_DISP_CTRL, v);
    chk_val("ctrl after reset", 14'h0000, 14'(v));
    chk_val("invert after reset", 14'h0000, 14'(screen_invert));
    chk_val("char after reset", 14'h0001, 14'(char_visible));
    give_verdict();
  end
endmodule
`default_nettype wire
